// ---- rtl/tls_map.svh ----
// Register offsets, field positions and reset values of the limit status bank
`ifndef TLS_MAP_SVH
`define TLS_MAP_SVH
`define TLS_UNDER_OFS 8'h36
`define TLS_OVER_OFS 8'h37
`define TLS_SMOOTH_OFS 8'h40
`define TLS_PART_OFS 8'hfd
`define TLS_MAKER_OFS 8'hfe
`define TLS_REV_OFS 8'hff
`define TLS_INT_BIT 0
`define TLS_EXT1_BIT 1
`define TLS_EXT2_BIT 2
`define TLS_FLAGS_RST 3'h0
`define TLS_SMOOTH_RST 2'h0
`define TLS_PART_VAL 8'ha1
`define TLS_MAKER_VAL 8'hb2
`define TLS_REV_VAL 8'h01
`endif

// ---- rtl/tls_pkg.sv ----
// Types of the limit status bank
package tls_pkg;
	typedef enum logic [1:0] {
		tls_filt_off,
		tls_filt_lvl1,
		tls_filt_lvl2
	} tls_filt_type;
	typedef struct packed {
		logic [2:0] under;
		logic [2:0] over;
	} tls_cmp_type;
	typedef struct packed {
		logic low;
		logic therm;
	} tls_sum_type;
endpackage : tls_pkg

// ---- rtl/tls_regs.sv ----
// Limit status flags, smoothing control and identification registers
`timescale 1ns/1ps
`include "tls_map.svh"
// ==========================================================================
// How it works
// - Ext2 below low limit sets bit 2
// - Ext1 below low limit sets bit 1
// - Internal below low limit sets bit 0
// - Reading under flags clears them and summary
// - Any under flag holds low summary set
// - Under flags sticky unless comparator mode
// - Over flags bits 2..0 drive therm summary
// - Reading over flags does not clear them
// - Over flag clears below limit minus hysteresis
// - Therm summary clears when all over clear
// - Ext2 over limit sets bit 2, pin
// - Ext1 over limit sets bit 1, pin
// - Internal over limit sets bit 0, pin
// - Two-bit smoothing field, 00 off default
// - Read-only part identifier register
// - Read-only maker identifier register
// - Read-only die revision register
module tls_regs (
	// Clock and reset
	input wire logic i_ref_clk,
	input wire logic i_rst_n,
	// Register access from the serial bus engine
	input wire logic i_rd_en,
	input wire logic i_wr_en,
	input wire logic [7:0] i_addr,
	input wire logic [7:0] i_wdata,
	output logic [7:0] o_rdata,
	// Compare results, one bit per channel, and comparator mode select
	input wire tls_pkg::tls_cmp_type i_cmp,
	input wire logic [2:0] i_over_clear,
	input wire logic i_comparator_mode,
	// Status outputs
	output tls_pkg::tls_sum_type o_sum,
	output logic o_overtemp_n,
	output tls_pkg::tls_filt_type o_filt_level
);
	// ======================================================================
	// Flags
	logic [2:0] under_limit_flags;
	logic [2:0] overtemp_limit_flags;
	logic [1:0] smoothing_control;
	logic [2:0] next_under;
	logic [2:0] next_over;
	logic rd_under;
	assign rd_under = i_rd_en && (i_addr == `TLS_UNDER_OFS);
	genvar g;
	generate
		for (g = 0; g < 3; g++) begin : g_ch
			// Set wins over a read clear in the same cycle
			always_comb begin
				if (i_comparator_mode) begin
					next_under[g] = i_cmp.under[g];
				end else begin
					next_under[g] = i_cmp.under[g] ||
						(under_limit_flags[g] && !rd_under);
				end
				// Set beats the hysteresis clear
				next_over[g] = i_cmp.over[g] ||
					(overtemp_limit_flags[g] && !i_over_clear[g]);
			end
		end
	endgenerate
	always_ff @(posedge i_ref_clk) begin
		if (!i_rst_n) begin
			under_limit_flags <= `TLS_FLAGS_RST;
		end else begin
			under_limit_flags <= next_under;
		end
	end
	always_ff @(posedge i_ref_clk) begin
		if (!i_rst_n) begin
			overtemp_limit_flags <= `TLS_FLAGS_RST;
		end else begin
			overtemp_limit_flags <= next_over;
		end
	end
	// ======================================================================
	// Summary bits and pin, registered from next flag values
	always_ff @(posedge i_ref_clk) begin
		if (!i_rst_n) begin
			o_sum <= '0;
			o_overtemp_n <= 1'b1;
		end else begin
			o_sum.low <= |next_under;
			o_sum.therm <= |next_over;
			o_overtemp_n <= !(|next_over);
		end
	end
	// ======================================================================
	// Smoothing control, only writable register here
	always_ff @(posedge i_ref_clk) begin
		if (!i_rst_n) begin
			smoothing_control <= `TLS_SMOOTH_RST;
		end else if (i_wr_en && i_addr == `TLS_SMOOTH_OFS) begin
			smoothing_control <= i_wdata[1:0];
		end
	end
	always_ff @(posedge i_ref_clk) begin
		if (!i_rst_n) begin
			o_filt_level <= tls_pkg::tls_filt_off;
		end else begin
			case (smoothing_control)
				2'h0: o_filt_level <= tls_pkg::tls_filt_off;
				2'h3: o_filt_level <= tls_pkg::tls_filt_lvl2;
				default: o_filt_level <= tls_pkg::tls_filt_lvl1;
			endcase
		end
	end
	// ======================================================================
	// Read data; writes elsewhere have no target
	always_ff @(posedge i_ref_clk) begin
		if (!i_rst_n) begin
			o_rdata <= 8'h00;
		end else if (i_rd_en) begin
			case (i_addr)
				`TLS_UNDER_OFS: o_rdata <= {5'h00, under_limit_flags};
				`TLS_OVER_OFS: o_rdata <= {5'h00, overtemp_limit_flags};
				`TLS_SMOOTH_OFS: o_rdata <= {6'h00, smoothing_control};
				`TLS_PART_OFS: o_rdata <= `TLS_PART_VAL;
				`TLS_MAKER_OFS: o_rdata <= `TLS_MAKER_VAL;
				`TLS_REV_OFS: o_rdata <= `TLS_REV_VAL;
				default: o_rdata <= 8'h00;
			endcase
		end
	end
	// ======================================================================
	// Checks
	sequence s_under_read;
		rd_under && !i_comparator_mode && i_cmp.under == 3'h0;
	endsequence
	property p_under_set;
		@(posedge i_ref_clk) disable iff (!i_rst_n)
		i_cmp.under[2] |=> under_limit_flags[2];
	endproperty
	a_under_set: assert property (p_under_set)
		else $error("ext2 under flag not set");
	property p_under_set1;
		@(posedge i_ref_clk) disable iff (!i_rst_n)
		i_cmp.under[1] |=> under_limit_flags[1];
	endproperty
	a_under_set1: assert property (p_under_set1)
		else $error("ext1 under flag not set");
	property p_under_set0;
		@(posedge i_ref_clk) disable iff (!i_rst_n)
		i_cmp.under[0] |=> under_limit_flags[0];
	endproperty
	a_under_set0: assert property (p_under_set0)
		else $error("internal under flag not set");
	property p_under_clr;
		@(posedge i_ref_clk) disable iff (!i_rst_n)
		s_under_read |=> under_limit_flags == 3'h0 && !o_sum.low;
	endproperty
	a_under_clr: assert property (p_under_clr)
		else $error("under read did not clear");
	property p_low_sum;
		@(posedge i_ref_clk) disable iff (!i_rst_n)
		|under_limit_flags |-> o_sum.low;
	endproperty
	a_low_sum: assert property (p_low_sum)
		else $error("low summary missing");
	property p_sticky;
		@(posedge i_ref_clk) disable iff (!i_rst_n)
		under_limit_flags[0] && !rd_under && !i_comparator_mode
			|=> under_limit_flags[0];
	endproperty
	a_sticky: assert property (p_sticky)
		else $error("under flag lost");
	property p_over_keep;
		@(posedge i_ref_clk) disable iff (!i_rst_n)
		i_rd_en && i_addr == `TLS_OVER_OFS && i_over_clear == 3'h0 &&
			i_cmp.over == 3'h0
			|=> overtemp_limit_flags == $past(overtemp_limit_flags);
	endproperty
	a_over_keep: assert property (p_over_keep)
		else $error("over flags changed on read");
	property p_pin;
		@(posedge i_ref_clk) disable iff (!i_rst_n)
		o_overtemp_n == !(|overtemp_limit_flags) &&
			o_sum.therm == |overtemp_limit_flags;
	endproperty
	a_pin: assert property (p_pin)
		else $error("therm summary or pin wrong");
	property p_smooth;
		@(posedge i_ref_clk) disable iff (!i_rst_n)
		i_wr_en && i_addr == `TLS_SMOOTH_OFS && i_wdata[1:0] == 2'h3
			|=> ##1 o_filt_level == tls_pkg::tls_filt_lvl2;
	endproperty
	a_smooth: assert property (p_smooth)
		else $error("smoothing level wrong");
	property p_id;
		@(posedge i_ref_clk) disable iff (!i_rst_n)
		i_rd_en && i_addr == `TLS_PART_OFS |=> o_rdata == `TLS_PART_VAL;
	endproperty
	a_id: assert property (p_id)
		else $error("part id wrong");
	// ======================================================================
	// Over flags, pin, hysteresis clear, comparator follow and flag read data
	sequence s_smooth_wr;
		i_wr_en && i_addr == `TLS_SMOOTH_OFS;
	endsequence
	property p_over_set2;
		@(posedge i_ref_clk) disable iff (!i_rst_n)
		i_cmp.over[2] |=> overtemp_limit_flags[2] && !o_overtemp_n;
	endproperty
	a_over_set2: assert property (p_over_set2)
		else $error("ext2 over flag or pin not set");
	property p_over_set1;
		@(posedge i_ref_clk) disable iff (!i_rst_n)
		i_cmp.over[1] |=> overtemp_limit_flags[1] && !o_overtemp_n;
	endproperty
	a_over_set1: assert property (p_over_set1)
		else $error("ext1 over flag or pin not set");
	property p_over_set0;
		@(posedge i_ref_clk) disable iff (!i_rst_n)
		i_cmp.over[0] |=> overtemp_limit_flags[0] && !o_overtemp_n;
	endproperty
	a_over_set0: assert property (p_over_set0)
		else $error("internal over flag or pin not set");
	property p_over_clr2;
		@(posedge i_ref_clk) disable iff (!i_rst_n)
		i_over_clear[2] && !i_cmp.over[2] |=> !overtemp_limit_flags[2];
	endproperty
	a_over_clr2: assert property (p_over_clr2)
		else $error("ext2 over flag not cleared");
	property p_over_clr1;
		@(posedge i_ref_clk) disable iff (!i_rst_n)
		i_over_clear[1] && !i_cmp.over[1] |=> !overtemp_limit_flags[1];
	endproperty
	a_over_clr1: assert property (p_over_clr1)
		else $error("ext1 over flag not cleared");
	property p_over_clr0;
		@(posedge i_ref_clk) disable iff (!i_rst_n)
		i_over_clear[0] && !i_cmp.over[0] |=> !overtemp_limit_flags[0];
	endproperty
	a_over_clr0: assert property (p_over_clr0)
		else $error("internal over flag not cleared");
	property p_over_hold;
		@(posedge i_ref_clk) disable iff (!i_rst_n)
		overtemp_limit_flags[1] && !i_over_clear[1] |=> overtemp_limit_flags[1];
	endproperty
	a_over_hold: assert property (p_over_hold)
		else $error("over flag dropped without clear");
	property p_comp_follow;
		@(posedge i_ref_clk) disable iff (!i_rst_n)
		i_comparator_mode |=> under_limit_flags == $past(i_cmp.under);
	endproperty
	a_comp_follow: assert property (p_comp_follow)
		else $error("under flags not following compare");
	property p_over_rd;
		@(posedge i_ref_clk) disable iff (!i_rst_n)
		i_rd_en && i_addr == `TLS_OVER_OFS
			|=> o_rdata == {5'h00, $past(overtemp_limit_flags)};
	endproperty
	a_over_rd: assert property (p_over_rd)
		else $error("over flag read data wrong");
	property p_under_rd;
		@(posedge i_ref_clk) disable iff (!i_rst_n)
		i_rd_en && i_addr == `TLS_UNDER_OFS
			|=> o_rdata == {5'h00, $past(under_limit_flags)};
	endproperty
	a_under_rd: assert property (p_under_rd)
		else $error("under flag read data wrong");
	// ======================================================================
	// Identification, write protection, smoothing and reset
	property p_maker;
		@(posedge i_ref_clk) disable iff (!i_rst_n)
		i_rd_en && i_addr == `TLS_MAKER_OFS |=> o_rdata == `TLS_MAKER_VAL;
	endproperty
	a_maker: assert property (p_maker)
		else $error("maker id wrong");
	property p_rev;
		@(posedge i_ref_clk) disable iff (!i_rst_n)
		i_rd_en && i_addr == `TLS_REV_OFS |=> o_rdata == `TLS_REV_VAL;
	endproperty
	a_rev: assert property (p_rev)
		else $error("revision code wrong");
	property p_ro_write;
		@(posedge i_ref_clk) disable iff (!i_rst_n)
		i_wr_en && i_addr != `TLS_SMOOTH_OFS
			|=> smoothing_control == $past(smoothing_control);
	endproperty
	a_ro_write: assert property (p_ro_write)
		else $error("write to read-only offset changed state");
	property p_smooth_off;
		@(posedge i_ref_clk) disable iff (!i_rst_n)
		s_smooth_wr ##0 i_wdata[1:0] == 2'h0
			|=> ##1 o_filt_level == tls_pkg::tls_filt_off;
	endproperty
	a_smooth_off: assert property (p_smooth_off)
		else $error("smoothing off wrong");
	property p_smooth_lvl1;
		@(posedge i_ref_clk) disable iff (!i_rst_n)
		s_smooth_wr ##0 (i_wdata[1:0] == 2'h1 || i_wdata[1:0] == 2'h2)
			|=> ##1 o_filt_level == tls_pkg::tls_filt_lvl1;
	endproperty
	a_smooth_lvl1: assert property (p_smooth_lvl1)
		else $error("smoothing level one wrong");
	property p_rst;
		@(posedge i_ref_clk)
		!i_rst_n |=> under_limit_flags == 3'h0 &&
			overtemp_limit_flags == 3'h0 && !o_sum.low && !o_sum.therm &&
			o_overtemp_n && o_rdata == 8'h00 &&
			smoothing_control == `TLS_SMOOTH_RST;
	endproperty
	a_rst: assert property (p_rst)
		else $error("reset values wrong");
endmodule : tls_regs

// ---- tb/tb_temp_limit_status_regs.sv ----
// Self-checking bench for the limit status bank
`timescale 1ns/1ps
`include "tls_map.svh"
// ==========================================================
// Bench
module tb_temp_limit_status_regs;
	logic i_ref_clk, i_rst_n, mode, rd, wr, ovt_n;
	logic [7:0] addr, wdata, rdata, r;
	logic [2:0] oclr, mu, mo;
	tls_pkg::tls_cmp_type cmp;
	tls_pkg::tls_sum_type sum;
	tls_pkg::tls_filt_type filt;
	int miscompares, check_count;
	tls_host u_tls_host (.i_ref_clk(i_ref_clk), .o_rd_en(rd),
		.o_wr_en(wr), .o_addr(addr), .o_wdata(wdata));
	tls_regs u_tls_regs (.i_ref_clk(i_ref_clk), .i_rst_n(i_rst_n),
		.i_rd_en(rd), .i_wr_en(wr), .i_addr(addr), .i_wdata(wdata),
		.o_rdata(rdata), .i_cmp(cmp), .i_over_clear(oclr),
		.i_comparator_mode(mode), .o_sum(sum), .o_overtemp_n(ovt_n),
		.o_filt_level(filt));
	initial begin
		i_ref_clk = 1'b0;
		forever #10 i_ref_clk = ~i_ref_clk;
	end
	function logic [7:0] next_lfsr(input logic [7:0] v);
		return {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
	endfunction : next_lfsr
	task chk(input string n, input logic [7:0] e, input logic [7:0] s);
		check_count++;
		if (s !== e) begin
			miscompares++;
			$display("CHECK FAILED %s exp %h got %h", n, e, s);
		end
	endtask : chk
	task rdc(input logic [7:0] a, input logic [7:0] e);
		u_tls_host.xfer(1'b0, a, 8'h00);
		chk("rdata", e, rdata);
	endtask : rdc
	task wrap_up;
		$display("checks %0d miscompares %0d", check_count, miscompares);
		if (miscompares == 0 && check_count > 0) $display("TEST PASSED");
		else $display("TEST FAILED");
		$finish;
	endtask : wrap_up
	initial begin
		i_rst_n = 1'b0;
		mode = 1'b0;
		cmp = '0;
		oclr = 3'h0;
		mu = 3'h0;
		mo = 3'h0;
		r = 8'h25;
		repeat (4) @(negedge i_ref_clk);
		i_rst_n = 1'b1;
		chk("pin", 8'h01, {7'h00, ovt_n});
		rdc(`TLS_OVER_OFS, 8'h00);
		rdc(`TLS_SMOOTH_OFS, 8'h00);
		rdc(8'h50, 8'h00);
		for (int k = 0; k < 4; k++) begin
			u_tls_host.xfer(1'b1, 8'hfd + k[7:0], 8'h5a);
			if (k == 3) u_tls_host.xfer(1'b1, `TLS_OVER_OFS, 8'h07);
		end
		rdc(`TLS_PART_OFS, `TLS_PART_VAL);
		rdc(`TLS_MAKER_OFS, `TLS_MAKER_VAL);
		rdc(`TLS_REV_OFS, `TLS_REV_VAL);
		rdc(`TLS_OVER_OFS, 8'h00);
		$display("id test done");
		for (int i = 0; i < 8; i++) begin
			r = next_lfsr(r);
			@(negedge i_ref_clk);
			cmp = {r[2:0], r[5:3]};
			@(negedge i_ref_clk);
			cmp = '0;
			mu = mu | r[2:0];
			mo = mo | r[5:3];
			chk("low", {7'h00, |mu}, {7'h00, sum.low});
			chk("therm", {7'h00, |mo}, {7'h00, sum.therm});
			chk("pin", {7'h00, ~|mo}, {7'h00, ovt_n});
			rdc(`TLS_OVER_OFS, {5'h00, mo});
			rdc(`TLS_OVER_OFS, {5'h00, mo});
			rdc(`TLS_UNDER_OFS, {5'h00, mu});
			mu = 3'h0;
			chk("low", 8'h00, {7'h00, sum.low});
			rdc(`TLS_UNDER_OFS, 8'h00);
			r = next_lfsr(r);
			oclr = r[2:0];
			@(negedge i_ref_clk);
			oclr = 3'h0;
			mo = mo & ~r[2:0];
			@(negedge i_ref_clk);
			chk("therm", {7'h00, |mo}, {7'h00, sum.therm});
			chk("pin", {7'h00, ~|mo}, {7'h00, ovt_n});
			rdc(`TLS_OVER_OFS, {5'h00, mo});
		end
		$display("flag test done");
		// Comparator mode: flags follow compare, no read needed to drop
		mode = 1'b1;
		for (int j = 0; j < 4; j++) begin
			r = next_lfsr(r);
			@(negedge i_ref_clk);
			cmp.under = r[2:0];
			@(negedge i_ref_clk);
			chk("low", {7'h00, |r[2:0]}, {7'h00, sum.low});
			rdc(`TLS_UNDER_OFS, {5'h00, r[2:0]});
			chk("low", {7'h00, |r[2:0]}, {7'h00, sum.low});
			cmp.under = 3'h0;
			@(negedge i_ref_clk);
			chk("low", 8'h00, {7'h00, sum.low});
		end
		mode = 1'b0;
		@(negedge i_ref_clk);
		rdc(`TLS_UNDER_OFS, 8'h00);
		$display("comparator test done");
		for (int c = 0; c < 4; c++) begin
			u_tls_host.xfer(1'b1, `TLS_SMOOTH_OFS, c[7:0]);
			@(negedge i_ref_clk);
			chk("filt", (c == 3) ? 8'h02 : (c > 0) ? 8'h01 : 8'h00,
				{6'h00, filt});
			rdc(`TLS_SMOOTH_OFS, c[7:0]);
		end
		$display("smoothing test done");
		wrap_up;
	end
endmodule : tb_temp_limit_status_regs

// ---- tb/tls_host.sv ----
// Register bus host model for the limit status bank
`timescale 1ns/1ps
// ==========================================================
// Host
module tls_host (
	// Clock
	input wire logic i_ref_clk,
	// Requests
	output logic o_rd_en,
	output logic o_wr_en,
	output logic [7:0] o_addr,
	output logic [7:0] o_wdata
);
	initial begin
		o_rd_en = 1'b0;
		o_wr_en = 1'b0;
		o_addr = 8'h00;
		o_wdata = 8'h00;
	end
	// One strobe cycle; released lines show inverse, not stale data
	task xfer(input logic wr, input logic [7:0] a, input logic [7:0] d);
		@(negedge i_ref_clk);
		o_rd_en = !wr;
		o_wr_en = wr;
		o_addr = a;
		o_wdata = d;
		@(negedge i_ref_clk);
		o_rd_en = 1'b0;
		o_wr_en = 1'b0;
		o_addr = ~a;
		o_wdata = ~d;
	endtask : xfer
endmodule : tls_host
